// ### battery_switchover_control.sv
// Battery backup switchover control: mode logic, sampling and register port.
// Assumes a 200 MHz clock, an analog detector giving a drop level on a pin,
// and a low-voltage flag driven by status logic on the same clock.

module battery_switchover_control #(
  parameter int unsigned SECOND_CYCLES = switchover_pkg::SECOND_CYC,
  parameter int unsigned BACKUP_POLL_CYCLES = switchover_pkg::BACKUP_POLL_CYC,
  parameter int unsigned SAMPLE_SHORT_CYCLES = switchover_pkg::SAMPLE_SHORT_CYC,
  parameter int unsigned SAMPLE_LONG_CYCLES = switchover_pkg::SAMPLE_LONG_CYC,
  parameter int unsigned SAMPLE_ALT_CYCLES = switchover_pkg::SAMPLE_ALT_CYC
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Register port
  input wire logic [switchover_pkg::ADDR_W-1:0] addr_i,
  input wire logic [switchover_pkg::DATA_W-1:0] wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  output logic [switchover_pkg::DATA_W-1:0] rdata_o,
  // Supply detection and status
  input wire logic supply_drop_i,
  input wire logic low_voltage_flag_i,
  // Power path and host bus control
  output logic supply_path_switch_o,
  output logic detector_enable_o,
  output logic backup_mode_o,
  output logic host_bus_off_o
);
  import switchover_pkg::*;

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (SECOND_CYCLES < 2 || BACKUP_POLL_CYCLES < 1) begin : g_bad_period
    $error("Second and poll periods must be at least two and one cycles");
  end
  if (SAMPLE_SHORT_CYCLES >= SECOND_CYCLES || SAMPLE_LONG_CYCLES >= SECOND_CYCLES
      || SAMPLE_ALT_CYCLES >= SECOND_CYCLES) begin : g_bad_sample
    $error("Sampling intervals must be shorter than one second");
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Sampling interval length for a sample-time code
  function automatic logic [CNT_W-1:0] sample_cycles(input logic [1:0] code);
    logic [CNT_W-1:0] len;
    len = '0;
    unique case (code)
      SMPT_NONE: len = '0;
      SMPT_SHORT: len = CNT_W'(SAMPLE_SHORT_CYCLES);
      SMPT_LONG: len = CNT_W'(SAMPLE_LONG_CYCLES);
      default: len = CNT_W'(SAMPLE_ALT_CYCLES);
    endcase
    return len;
  endfunction

  // Register access is only honoured while the host bus is alive
  function automatic logic hit(input logic strobe, input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] target, input logic off);
    return strobe && (a == target) && !off;
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic drop_s1_r;
  logic drop_s2_r;
  logic drop_s3_r;
  logic drop_r;
  logic vlf_q_r;
  logic vlf_rise;
  logic enable_r;
  logic [1:0] select_r;
  logic [1:0] smpt_r;
  mode_e mode_r;
  mode_e mode_nxt;
  logic auto_ctrl;
  logic [CNT_W-1:0] sec_cnt_r;
  logic sec_tick;
  logic [CNT_W-1:0] poll_cnt_r;
  logic poll_tick;
  logic switch_nxt;
  logic switch_r;
  logic detect_r;
  logic bus_off_r;
  logic backup_r;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] ctrl_view;
  logic [DATA_W-1:0] stat_view;

  sample_if win ();

  // ****************************************************************
  // Supply drop input
  // ****************************************************************
  // Three-stage synchroniser; the level moves only once stages two and three agree
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      drop_s1_r <= 1'b0;
      drop_s2_r <= 1'b0;
      drop_s3_r <= 1'b0;
    end else begin
      drop_s1_r <= supply_drop_i;
      drop_s2_r <= drop_s1_r;
      drop_s3_r <= drop_s2_r;
    end
  end

  // Filtered drop level
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      drop_r <= 1'b0;
    end else if (drop_s2_r == drop_s3_r) begin
      drop_r <= drop_s3_r;
    end
  end

  // ****************************************************************
  // Low-voltage flag edge
  // ****************************************************************
  // Starts high so a flag already set at reset is not taken as a new rise
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      vlf_q_r <= 1'b1;
    end else begin
      vlf_q_r <= low_voltage_flag_i;
    end
  end

  assign vlf_rise = low_voltage_flag_i && !vlf_q_r;

  // ****************************************************************
  // Control register
  // ****************************************************************
  // Defaults win over a write in the same cycle as the flag rise
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      enable_r <= ENABLE_DEFAULT;
      select_r <= SEL_DEFAULT;
      smpt_r <= SMPT_DEFAULT;
    end else if (vlf_rise) begin
      enable_r <= ENABLE_DEFAULT;
      select_r <= SEL_DEFAULT;
      smpt_r <= SMPT_DEFAULT;
    end else if (hit(write_i, addr_i, CTRL_ADDR, bus_off_r)) begin
      enable_r <= wdata_i[ENABLE_BIT];
      select_r <= {wdata_i[SEL_HI_BIT], wdata_i[SEL_LO_BIT]};
      smpt_r <= {wdata_i[SMPT_HI_BIT], wdata_i[SMPT_LO_BIT]};
    end
  end

  // Select 11 with enable set keeps the switch open; other codes with enable set are automatic
  assign auto_ctrl = enable_r && (select_r != SEL_OPEN);

  // ****************************************************************
  // Mode machine
  // ****************************************************************
  // A drop is acted on the cycle it is seen; return waits for a backup poll
  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      MODE_LOCKED: begin
        if (enable_r) begin
          mode_nxt = drop_r ? MODE_BACKUP : MODE_NORMAL;
        end
      end
      MODE_NORMAL: begin
        if (!enable_r) begin
          mode_nxt = MODE_LOCKED;
        end else if (drop_r) begin
          mode_nxt = MODE_BACKUP;
        end
      end
      MODE_BACKUP: begin
        if (!enable_r) begin
          mode_nxt = MODE_LOCKED;
        end else if (poll_tick && !drop_r) begin
          mode_nxt = MODE_NORMAL;
        end
      end
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mode_r <= MODE_LOCKED;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // ****************************************************************
  // Timebases
  // ****************************************************************
  // One-second divider runs only in normal mode, so each entry restarts it
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sec_cnt_r <= '0;
    end else if (mode_r != MODE_NORMAL || sec_tick) begin
      sec_cnt_r <= '0;
    end else begin
      sec_cnt_r <= sec_cnt_r + 1'b1;
    end
  end

  assign sec_tick = (mode_r == MODE_NORMAL) &&
                    (sec_cnt_r == CNT_W'(SECOND_CYCLES - 1));

  // Backup poll divider for the intermittent detector check
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      poll_cnt_r <= '0;
    end else if (mode_r != MODE_BACKUP || poll_tick) begin
      poll_cnt_r <= '0;
    end else begin
      poll_cnt_r <= poll_cnt_r + 1'b1;
    end
  end

  assign poll_tick = (mode_r == MODE_BACKUP) &&
                     (poll_cnt_r == CNT_W'(BACKUP_POLL_CYCLES - 1));

  // ****************************************************************
  // Sampling window
  // ****************************************************************
  // Interval length follows the sample-time code; code 00 never opens
  assign win.length = sample_cycles(smpt_r);
  assign win.start = sec_tick && auto_ctrl && (win.length != '0);
  assign win.cancel = (mode_nxt != MODE_NORMAL) || !auto_ctrl;

  sample_window_timer u_window (
    .clock_i (clock_i),
    .rst_i (rst_i),
    .win (win.timer)
  );

  // ****************************************************************
  // Switch and detector
  // ****************************************************************
  // Locked mode takes the switch from the select bits alone; the forbidden
  // codes 00 and 11 fall to open, which is the safe side
  always_comb begin
    switch_nxt = 1'b0;
    unique case (mode_nxt)
      MODE_LOCKED: switch_nxt = (select_r == SEL_CLOSED);
      MODE_NORMAL: switch_nxt = auto_ctrl && !win.busy && !win.start;
      MODE_BACKUP: switch_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      switch_r <= 1'b0;
    end else begin
      switch_r <= switch_nxt;
    end
  end

  // Detector: on in normal, stopped when locked, one strobe per backup poll when the poll is longer than one cycle
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      detect_r <= 1'b0;
    end else begin
      detect_r <= (mode_nxt == MODE_NORMAL) ||
                  ((mode_r == MODE_BACKUP) &&
                   (poll_cnt_r == CNT_W'(BACKUP_POLL_CYCLES - 1)) &&
                   (BACKUP_POLL_CYCLES > 1) && (mode_nxt == MODE_BACKUP));
    end
  end

  // ****************************************************************
  // Host bus and mode outputs
  // ****************************************************************
  // The bus is cut only in backup, which needs enable set; locked never cuts
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      bus_off_r <= 1'b0;
      backup_r <= 1'b0;
    end else begin
      bus_off_r <= (mode_nxt == MODE_BACKUP);
      backup_r <= (mode_nxt == MODE_BACKUP);
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  // Reserved bits stay zero whatever was written
  always_comb begin
    ctrl_view = '0;
    ctrl_view[ENABLE_BIT] = enable_r;
    ctrl_view[SEL_HI_BIT] = select_r[1];
    ctrl_view[SEL_LO_BIT] = select_r[0];
    ctrl_view[SMPT_HI_BIT] = smpt_r[1];
    ctrl_view[SMPT_LO_BIT] = smpt_r[0];
    stat_view = '0;
    stat_view[STAT_BACKUP_BIT] = backup_r;
    stat_view[STAT_SWITCH_BIT] = switch_r;
    stat_view[STAT_WINDOW_BIT] = win.busy;
    stat_view[STAT_BUSOFF_BIT] = bus_off_r;
    stat_view[STAT_DROP_BIT] = drop_r;
  end

  // Read data stand for the one cycle after the strobe, zero otherwise
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= '0;
    end else if (hit(read_i, addr_i, CTRL_ADDR, bus_off_r)) begin
      rdata_r <= ctrl_view;
    end else if (hit(read_i, addr_i, STAT_ADDR, bus_off_r)) begin
      rdata_r <= stat_view;
    end else begin
      rdata_r <= '0;
    end
  end

  assign rdata_o = rdata_r;
  assign supply_path_switch_o = switch_r;
  assign detector_enable_o = detect_r;
  assign backup_mode_o = backup_r;
  assign host_bus_off_o = bus_off_r;

endmodule // battery_switchover_control

// ### switchover_pkg.sv
// Constants, register layout and mode codes of the battery switchover control.
// Assumes a single 200 MHz clock and a byte-wide register port.
package switchover_pkg;

  // ****************************************************************
  // Register port
  // ****************************************************************
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h02;
  localparam logic [ADDR_W-1:0] STAT_ADDR = 8'h03;

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int unsigned ENABLE_BIT = 6;
  localparam int unsigned SEL_HI_BIT = 3;
  localparam int unsigned SEL_LO_BIT = 2;
  localparam int unsigned SMPT_HI_BIT = 1;
  localparam int unsigned SMPT_LO_BIT = 0;
  localparam logic ENABLE_DEFAULT = 1'b0;
  localparam logic [1:0] SEL_DEFAULT = 2'h1;
  localparam logic [1:0] SEL_CLOSED = 2'h2;
  localparam logic [1:0] SEL_OPEN = 2'h3;
  localparam logic [1:0] SMPT_DEFAULT = 2'h0;
  localparam logic [1:0] SMPT_NONE = 2'h0;
  localparam logic [1:0] SMPT_SHORT = 2'h1;
  localparam logic [1:0] SMPT_LONG = 2'h2;

  // ****************************************************************
  // Status register fields
  // ****************************************************************
  localparam int unsigned STAT_BACKUP_BIT = 0;
  localparam int unsigned STAT_SWITCH_BIT = 1;
  localparam int unsigned STAT_WINDOW_BIT = 2;
  localparam int unsigned STAT_BUSOFF_BIT = 3;
  localparam int unsigned STAT_DROP_BIT = 4;

  // ****************************************************************
  // Timing, in nanoseconds, and derived cycle counts
  // ****************************************************************
  localparam int unsigned CNT_W = 32;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned SECOND_NS = 1_000_000_000;
  localparam int unsigned BACKUP_POLL_NS = 31_250_000;
  localparam int unsigned SAMPLE_SHORT_NS = 2_000_000;
  localparam int unsigned SAMPLE_LONG_NS = 128_000_000;
  localparam int unsigned SAMPLE_ALT_NS = 2_000_000;
  localparam int unsigned SECOND_CYC = SECOND_NS / CLK_PERIOD_NS;
  localparam int unsigned BACKUP_POLL_CYC = BACKUP_POLL_NS / CLK_PERIOD_NS;
  localparam int unsigned SAMPLE_SHORT_CYC = SAMPLE_SHORT_NS / CLK_PERIOD_NS;
  localparam int unsigned SAMPLE_LONG_CYC = SAMPLE_LONG_NS / CLK_PERIOD_NS;
  localparam int unsigned SAMPLE_ALT_CYC = SAMPLE_ALT_NS / CLK_PERIOD_NS;

  // ****************************************************************
  // Power modes
  // ****************************************************************
  typedef enum logic [2:0] {
    MODE_LOCKED = 3'b001,
    MODE_NORMAL = 3'b010,
    MODE_BACKUP = 3'b100
  } mode_e;

endpackage

// ### sample_if.sv
// Carrier between the mode controller and the sampling window timer.
// Assumes both ends run on the same clock.
interface sample_if;
  import switchover_pkg::*;
  logic start;
  logic cancel;
  logic busy;
  logic [CNT_W-1:0] length;
  modport ctrl (output start, output cancel, output length, input busy);
  modport timer (input start, input cancel, input length, output busy);
endinterface

// ### sample_window_timer.sv
// Window timer: busy covers the cycles of a window after its start cycle.
// Assumes start is a one-cycle pulse and cancel a level, both from the same clock.
module sample_window_timer (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Window request and state
  sample_if.timer win
);
  import switchover_pkg::*;

  // ****************************************************************
  // Window counter
  // ****************************************************************
  logic busy_r;
  logic [CNT_W-1:0] remain_r;

  // Cancel beats start, so a supply drop never leaves a window running into backup
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      busy_r <= 1'b0;
      remain_r <= '0;
    end else if (win.cancel) begin
      busy_r <= 1'b0;
      remain_r <= '0;
    end else if (win.start && (win.length != '0)) begin
      busy_r <= 1'b1;
      remain_r <= win.length - 1'b1;
    end else if (busy_r) begin
      if (remain_r == '0) begin
        busy_r <= 1'b0;
      end else begin
        remain_r <= remain_r - 1'b1;
      end
    end
  end

  // The caller's start cycle is the first window cycle, so busy drops on the
  // last count; this keeps the registered switch open for exactly length cycles
  assign win.busy = busy_r && (remain_r != '0);

endmodule // sample_window_timer

// ### switchover_checker.sv
// Concurrent checks on the top ports of the battery switchover control.
// Assumes one clock domain and an active-high asynchronous reset.
module switchover_checker #(
  parameter int unsigned BACKUP_POLL_CYCLES = 20
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Register port
  input wire logic [switchover_pkg::ADDR_W-1:0] addr_i,
  input wire logic read_i,
  input wire logic [switchover_pkg::DATA_W-1:0] rdata_o,
  // Supply lines and outputs
  input wire logic supply_drop_i,
  input wire logic low_voltage_flag_i,
  input wire logic supply_path_switch_o,
  input wire logic detector_enable_o,
  input wire logic backup_mode_o,
  input wire logic host_bus_off_o
);
  import switchover_pkg::*;
  // ****************************************************************
  // Common clocking
  // ****************************************************************
  // Slack on the poll bound covers where the poll counter starts
  localparam int POLL_MAX = BACKUP_POLL_CYCLES + 5;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  // A poll pulse, or an exit from backup, comes within one poll period
  sequence seq_poll;
    ##[0:POLL_MAX] (detector_enable_o || !backup_mode_o);
  endsequence
  // ****************************************************************
  // Assertions
  // ****************************************************************
  chk_drop_bus_off: assert property ((detector_enable_o && !backup_mode_o && supply_drop_i) [*3] |=>
    ##[0:2] host_bus_off_o)
    else $error("bus not cut after a supply drop in normal mode");
  chk_backup_switch_open: assert property (backup_mode_o |-> !supply_path_switch_o)
    else $error("switch closed in backup mode");
  // The filtered level lags the pin by three to four cycles
  chk_bus_off_cause: assert property ($rose(host_bus_off_o) |->
    $past(supply_drop_i, 4) || $past(supply_drop_i, 5))
    else $error("bus turned off without a supply drop");
  chk_reserved_zero: assert property ($past(read_i && addr_i == CTRL_ADDR) |->
    rdata_o[7] == 1'b0 && rdata_o[5:4] == 2'h0)
    else $error("reserved control bits not zero");
  chk_rdata_idle: assert property (!$past(read_i) |-> rdata_o == '0)
    else $error("read data outside the answer cycle");
  chk_refused_read: assert property (host_bus_off_o && read_i |=> rdata_o == '0)
    else $error("read answered while bus off");
  chk_poll_pulse: assert property (detector_enable_o && backup_mode_o |=>
    !detector_enable_o || !backup_mode_o)
    else $error("detector held on in backup");
  chk_backup_poll: assert property ($rose(backup_mode_o) |-> seq_poll)
    else $error("no detector poll in backup");
  chk_flag_default: assert property ($rose(low_voltage_flag_i) |->
    ##[1:4] (!supply_path_switch_o && !detector_enable_o))
    else $error("fields not back to default after flag rise");
endmodule // switchover_checker

bind battery_switchover_control switchover_checker #(
  .BACKUP_POLL_CYCLES(BACKUP_POLL_CYCLES)
) chk_u (
  .clock_i(clock_i),
  .rst_i(rst_i),
  .addr_i(addr_i),
  .read_i(read_i),
  .rdata_o(rdata_o),
  .supply_drop_i(supply_drop_i),
  .low_voltage_flag_i(low_voltage_flag_i),
  .supply_path_switch_o(supply_path_switch_o),
  .detector_enable_o(detector_enable_o),
  .backup_mode_o(backup_mode_o),
  .host_bus_off_o(host_bus_off_o)
);

// ### supply_model.sv
// Model of the supply detection side: comparator pin and low-voltage flag.
// Assumes the bench commands a drop or a flag level on its request inputs.
module supply_model (
  // Clock
  input wire logic clock_i,
  // Commands from the bench
  input wire logic drop_req_i,
  input wire logic lvf_req_i,
  // Lines into the block
  output logic supply_drop_o,
  output logic low_voltage_flag_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Both lines start at supply good
  initial begin
    supply_drop_o = 1'b0;
    low_voltage_flag_o = 1'b0;
  end
  // Comparator is analog, so it moves off the clock edge
  always @(drop_req_i) begin
    supply_drop_o <= #2 drop_req_i;
  end
  // Flag logic shares the clock, so it is registered
  always @(posedge clock_i) begin
    low_voltage_flag_o <= lvf_req_i;
  end
endmodule // supply_model

// ### tb.sv
// Self-checking bench of the battery switchover control with short counts.
// Assumes the supply model and the bound checker are compiled alongside.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import switchover_pkg::*;
  // ****************************************************************
  // Signals and table
  // ****************************************************************
  typedef struct {logic [7:0] wr; logic [7:0] rd; logic [1:0] sw_det;} row_s;
  localparam int SEC = 100;
  int lens [4] = '{0, 5, 10, 7};
  row_s rows [4] = '{'{8'h08, 8'h08, 2'b10}, '{8'hff, 8'h4f, 2'b01},
                     '{8'h44, 8'h44, 2'b11}, '{8'h04, 8'h04, 2'b00}};
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic write_i = 1'b0;
  logic read_i = 1'b0;
  logic drop_req = 1'b0;
  logic lvf_req = 1'b0;
  logic [7:0] rdata_o;
  logic drop, lvf, sw, det, backup, bus_off;
  logic [7:0] d;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;
  int n, m;
  // 200 MHz clock and a cap on run length
  always #2.5 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end
  supply_model sup_u (.clock_i(clock_i), .drop_req_i(drop_req), .lvf_req_i(lvf_req),
    .supply_drop_o(drop), .low_voltage_flag_o(lvf));
  battery_switchover_control #(.SECOND_CYCLES(SEC), .BACKUP_POLL_CYCLES(20),
    .SAMPLE_SHORT_CYCLES(5), .SAMPLE_LONG_CYCLES(10), .SAMPLE_ALT_CYCLES(7)) dut_u (
    .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o), .supply_drop_i(drop),
    .low_voltage_flag_i(lvf), .supply_path_switch_o(sw), .detector_enable_o(det),
    .backup_mode_o(backup), .host_bus_off_o(bus_off));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Sample one nanosecond after the edge, when outputs have settled
  task automatic tick();
    @(posedge clock_i);
    #1;
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock_i);
    write_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge clock_i);
    write_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe edge
  task automatic reg_read(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock_i);
    read_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    read_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask
  // Bounded wait for the switch to reach a level, counting cycles
  task automatic wait_sw(input logic lvl, input int max, output int k);
    k = 0;
    while (sw !== lvl && k < max) begin
      tick();
      k++;
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    #1;
    check("reset outputs", 8'h00, {4'h0, sw, det, backup, bus_off});
    reg_read(CTRL_ADDR, d);
    check("reset ctrl", 8'h04, d);
    reg_write(8'h10, 8'hff);
    reg_read(8'h10, d);
    check("unmapped read", 8'h00, d);
    // Ordinary mode settings from the table
    for (int i = 0; i < 4; i++) begin
      reg_write(CTRL_ADDR, rows[i].wr);
      repeat (3) tick();
      reg_read(CTRL_ADDR, d);
      check("ctrl readback", rows[i].rd, d);
      check("switch detector", {6'h0, rows[i].sw_det}, {6'h0, sw, det});
    end
    // Window length per sample code and one opening per second
    for (int s = 1; s < 4; s++) begin
      reg_write(CTRL_ADDR, 8'h04);
      reg_write(CTRL_ADDR, 8'h44 | 8'(s));
      wait_sw(1'b1, 20, n);
      wait_sw(1'b0, 150, n);
      wait_sw(1'b1, 50, n);
      check("window length", 8'(lens[s]), 8'(n));
      wait_sw(1'b0, 150, m);
      check("window period", 8'(SEC), 8'(n + m));
    end
    // Drop in mid-window enters backup before the window would end
    reg_write(CTRL_ADDR, 8'h04);
    reg_write(CTRL_ADDR, 8'h46);
    wait_sw(1'b1, 20, n);
    wait_sw(1'b0, 150, n);
    repeat (2) @(posedge clock_i);
    drop_req <= 1'b1;
    n = 0;
    while (backup !== 1'b1 && n < 6) begin
      tick();
      n++;
    end
    check("backup entry", 8'h01, {7'h0, backup});
    check("bus off", 8'h02, {6'h0, bus_off, sw});
    reg_read(CTRL_ADDR, d);
    check("refused read", 8'h00, d);
    n = 0;
    while (det !== 1'b1 && n < 30) begin
      tick();
      n++;
    end
    check("backup poll", 8'h01, {7'h0, det});
    @(posedge clock_i);
    drop_req <= 1'b0;
    n = 0;
    while (backup !== 1'b0 && n < 60) begin
      tick();
      n++;
    end
    check("backup exit", 8'h00, {6'h0, backup, bus_off});
    reg_read(CTRL_ADDR, d);
    check("ctrl after backup", 8'h46, d);
    // Locked closed: a drop never cuts the bus
    reg_write(CTRL_ADDR, 8'h08);
    @(posedge clock_i);
    drop_req <= 1'b1;
    repeat (10) tick();
    check("locked drop", 8'h04, {5'h0, sw, backup, bus_off});
    reg_read(STAT_ADDR, d);
    check("locked status", 8'h12, d);
    @(posedge clock_i);
    drop_req <= 1'b0;
    // Let the filtered drop clear, so enabling does not fall into backup
    repeat (4) tick();
    // Flag rise restores the defaults
    reg_write(CTRL_ADDR, 8'h44);
    @(posedge clock_i);
    lvf_req <= 1'b1;
    repeat (4) tick();
    reg_read(CTRL_ADDR, d);
    check("flag default", 8'h04, d);
    @(posedge clock_i);
    lvf_req <= 1'b0;
    // Reset in mid-run clears the enable again
    reg_write(CTRL_ADDR, 8'h45);
    @(posedge clock_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    reg_read(CTRL_ADDR, d);
    check("second reset ctrl", 8'h04, d);
    tally_and_finish();
  end
endmodule // tb
